// ---- shared/paof_regs.vh ----
// Constants for the port alternate-function override block.
`ifndef PAOF_REGS_VH
`define PAOF_REGS_VH
`define PAOF_PB_WIDTH 8
`define PAOF_PC_WIDTH 8
`define PAOF_PD_WIDTH 8
`define PAOF_XMM_WIDTH 3
`define PAOF_PB_SS 0
`define PAOF_PB_SCK 1
`define PAOF_PB_MOSI 2
`define PAOF_PB_MISO 3
`define PAOF_PD_RX 2
`define PAOF_PD_TX 3
`define PAOF_PD_XCK 5
`define PAOF_PC_THRESHOLDS 24'h29_cbbf
`endif

// ---- hdl/paof_pin.v ----
// One pin's override combiner: overrides replace port register values.
`timescale 1ns/100ps
module paof_pin (
    // Port register view
    input wire reg_pullup,
    input wire reg_dir,
    input wire reg_outval,
    // Overrides
    input wire pullup_override_en,
    input wire pullup_override_val,
    input wire dir_override_en,
    input wire dir_override_val,
    input wire outval_override_en,
    input wire outval_override_val,
    input wire input_en_override_en,
    input wire input_en_override_val,
    input wire sleep_input_off,
    // Pin controls
    output wire pin_pullup,
    output wire pin_oe,
    output wire pin_out,
    output wire pin_input_en
);
    assign pin_pullup = pullup_override_en ? pullup_override_val : reg_pullup;
    assign pin_oe = dir_override_en ? dir_override_val : reg_dir;
    assign pin_out = outval_override_en ? outval_override_val : reg_outval;
    assign pin_input_en = input_en_override_en ? input_en_override_val : ~sleep_input_off;
endmodule

// ---- hdl/paof_top.v ----
// Alternate-function overrides for port B, port C and port D pins.
//
// Function
// - SPI slave forces serial clock to input.
// - SPI master leaves clock direction to software.
// - Forced clock input keeps latch-controlled pull-up.
// - SPI slave forces slave-select to input.
// - Slave SPI active only while select low.
// - Master leaves select direction, pull-up to software.
// - MISO and MOSI paths chosen by role.
// - Compare enables override port B 7..4 value.
// - Legacy mode: pin 7 only 8-bit compare.
// - Legacy mode makes port C output-only.
// - Port C carries address bits 15..8.
// - Port C claim per-pin mask threshold.
// - Port D pin 7 clocks second 8-bit timer.
// - Port D pin 6 clocks wide timer.
// - Direction bit 5 picks sync clock direction.
// - Sync clock pin active only in synchronous mode.
// - Port D pin 4 feeds capture input.
// - Pins 3, 2 feed interrupts, input kept on.
// - Transmitter forces pin 3 output with data.
// - Receiver forces port D pin 2 input.
// - Forced receive input keeps latch pull-up.
// - Legacy mode removes second USART functions.
`timescale 1ns/100ps
`include "paof_regs.vh"
module paof_top (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Global controls
    input wire legacy_mode,
    input wire global_pullup_disable,
    input wire sleep_input_off,
    // Port registers
    input wire [7:0] portb_dir,
    input wire [7:0] portb_latch,
    input wire [7:0] portc_dir,
    input wire [7:0] portc_latch,
    input wire [7:0] portd_dir,
    input wire [7:0] portd_latch,
    // Pin input levels
    input wire [7:0] portb_pin_in,
    input wire [7:0] portd_pin_in,
    // SPI
    input wire serial_periph_enable,
    input wire serial_master_select,
    input wire spi_master_output,
    input wire spi_slave_output,
    input wire spi_clock_output,
    output reg spi_master_input,
    output reg spi_slave_input,
    output reg spi_clock_input,
    output reg spi_select_active,
    // Compare outputs
    input wire timer_a_compare_en,
    input wire timer_a_compare_out,
    input wire wide_timer_compare_a_en,
    input wire wide_timer_compare_a,
    input wire wide_timer_compare_b_en,
    input wire wide_timer_compare_b,
    input wire wide_timer_compare_c_en,
    input wire wide_timer_compare_c,
    input wire timer_b_compare_en,
    input wire timer_b_compare_out,
    // External memory
    input wire ext_mem_enable,
    input wire [2:0] ext_addr_mask,
    input wire [7:0] ext_addr_high,
    // Timer inputs and interrupts
    output reg timer_b_ext_clock,
    output reg wide_timer_ext_clock,
    output reg wide_timer_capture_in,
    input wire ext_irq_two_enable,
    input wire ext_irq_three_enable,
    output reg ext_irq_two,
    output reg ext_irq_three,
    // Second USART
    input wire usart_b_sync_mode,
    input wire usart_b_sync_clock_out,
    input wire usart_b_tx_enable,
    input wire usart_b_transmit,
    input wire usart_b_rx_enable,
    output reg usart_b_sync_clock_in,
    output reg usart_b_receive,
    // Pin controls
    output wire [7:0] portb_pullup,
    output wire [7:0] portb_oe,
    output wire [7:0] portb_out,
    output wire [7:0] portb_input_en,
    output wire [7:0] portc_pullup,
    output wire [7:0] portc_oe,
    output wire [7:0] portc_out,
    output wire [7:0] portc_input_en,
    output wire [7:0] portd_pullup,
    output wire [7:0] portd_oe,
    output wire [7:0] portd_out,
    output wire [7:0] portd_input_en
);
    // Claim thresholds, three bits per pin, with pin 0 in the lowest field.
    localparam [23:0] PC_THR = `PAOF_PC_THRESHOLDS;

    reg [7:0] b_pue;
    reg [7:0] b_puv;
    reg [7:0] b_dde;
    reg [7:0] b_ddv;
    reg [7:0] b_pve;
    reg [7:0] b_pvv;
    reg [7:0] c_pue;
    reg [7:0] c_dde;
    reg [7:0] c_pve;
    reg [7:0] c_pvv;
    reg [7:0] d_pue;
    reg [7:0] d_puv;
    reg [7:0] d_dde;
    reg [7:0] d_ddv;
    reg [7:0] d_pve;
    reg [7:0] d_pvv;
    reg [7:0] d_die;
    reg spi_slave;
    reg spi_master;
    reg tx_on;
    reg rx_on;
    reg xck_on;
    reg [2:0] eff_mask;
    integer i;

    // Pulls are gated by the global disable as the port register would be.
    wire [7:0] b_reg_pull = portb_latch & ~portb_dir & {8{~global_pullup_disable}};
    wire [7:0] c_reg_pull = portc_latch & ~portc_dir & {8{~global_pullup_disable}};
    wire [7:0] d_reg_pull = portd_latch & ~portd_dir & {8{~global_pullup_disable}};

    always @* begin
        spi_slave = serial_periph_enable & ~serial_master_select;
        spi_master = serial_periph_enable & serial_master_select;

        // Port B low half: forced inputs keep their latch pull-up.
        b_pue = 8'h00;
        b_puv = 8'h00;
        b_dde = 8'h00;
        b_ddv = 8'h00;
        b_pve = 8'h00;
        b_pvv = 8'h00;
        b_pue[`PAOF_PB_SCK] = spi_slave;
        b_puv[`PAOF_PB_SCK] = portb_latch[`PAOF_PB_SCK] & ~global_pullup_disable;
        b_dde[`PAOF_PB_SCK] = spi_slave;
        b_pue[`PAOF_PB_SS] = spi_slave;
        b_puv[`PAOF_PB_SS] = portb_latch[`PAOF_PB_SS] & ~global_pullup_disable;
        b_dde[`PAOF_PB_SS] = spi_slave;

        // Master drives MOSI and clock; slave input forced on MOSI, MISO input in master.
        b_pue[`PAOF_PB_MOSI] = spi_slave;
        b_puv[`PAOF_PB_MOSI] = portb_latch[`PAOF_PB_MOSI] & ~global_pullup_disable;
        b_dde[`PAOF_PB_MOSI] = spi_slave;
        b_pve[`PAOF_PB_MOSI] = spi_master;
        b_pvv[`PAOF_PB_MOSI] = spi_master_output;
        b_pue[`PAOF_PB_MISO] = spi_master;
        b_puv[`PAOF_PB_MISO] = portb_latch[`PAOF_PB_MISO] & ~global_pullup_disable;
        b_dde[`PAOF_PB_MISO] = spi_master;
        b_pve[`PAOF_PB_MISO] = spi_slave;
        b_pvv[`PAOF_PB_MISO] = spi_slave_output;
        b_pve[`PAOF_PB_SCK] = spi_master;
        b_pvv[`PAOF_PB_SCK] = spi_clock_output;

        // Compare outputs touch only the value; direction stays with software.
        b_pve[4] = timer_a_compare_en;
        b_pvv[4] = timer_a_compare_out;
        b_pve[5] = wide_timer_compare_a_en;
        b_pvv[5] = wide_timer_compare_a;
        b_pve[6] = wide_timer_compare_b_en;
        b_pvv[6] = wide_timer_compare_b;
        b_pve[7] = timer_b_compare_en | (wide_timer_compare_c_en & ~legacy_mode);
        // Both sources enabled are merged by OR, a simple modulator.
        b_pvv[7] = (timer_b_compare_en & timer_b_compare_out) |
                   (wide_timer_compare_c_en & ~legacy_mode & wide_timer_compare_c);

        // Port C address claim; the mask reads as zero in legacy mode.
        eff_mask = legacy_mode ? 3'h0 : ext_addr_mask;
        for (i = 0; i < 8; i = i + 1) begin
            c_pue[i] = ext_mem_enable & ({1'b0, eff_mask} < {1'b0, PC_THR[3*i +: 3]});
        end
        // Legacy mode makes every port C pin drive, whether claimed or not.
        c_dde = c_pue | {8{legacy_mode}};
        c_pve = c_pue;
        c_pvv = ext_addr_high;

        // Port D: second USART functions vanish in legacy mode.
        tx_on = usart_b_tx_enable & ~legacy_mode;
        rx_on = usart_b_rx_enable & ~legacy_mode;
        xck_on = usart_b_sync_mode & ~legacy_mode;

        d_pue = 8'h00;
        d_puv = 8'h00;
        d_dde = 8'h00;
        d_ddv = 8'h00;
        d_pve = 8'h00;
        d_pvv = 8'h00;
        d_die = 8'h00;
        d_pue[`PAOF_PD_TX] = tx_on;
        d_dde[`PAOF_PD_TX] = tx_on;
        d_ddv[`PAOF_PD_TX] = 1'b1;
        d_pve[`PAOF_PD_TX] = tx_on;
        d_pvv[`PAOF_PD_TX] = usart_b_transmit;

        d_pue[`PAOF_PD_RX] = rx_on;
        d_puv[`PAOF_PD_RX] = portd_latch[`PAOF_PD_RX] & ~global_pullup_disable;
        d_dde[`PAOF_PD_RX] = rx_on;

        d_pve[`PAOF_PD_XCK] = xck_on & portd_dir[`PAOF_PD_XCK];
        d_pvv[`PAOF_PD_XCK] = usart_b_sync_clock_out;

        // Interrupt inputs stay awake in sleep while their source is enabled.
        d_die[`PAOF_PD_TX] = ext_irq_three_enable;
        d_die[`PAOF_PD_RX] = ext_irq_two_enable;
    end

    // One combiner per pin keeps the four override paths independent of each other.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : pin
            paof_pin u_b (
                .reg_pullup(b_reg_pull[g]),
                .reg_dir(portb_dir[g]),
                .reg_outval(portb_latch[g]),
                .pullup_override_en(b_pue[g]),
                .pullup_override_val(b_puv[g]),
                .dir_override_en(b_dde[g]),
                .dir_override_val(b_ddv[g]),
                .outval_override_en(b_pve[g]),
                .outval_override_val(b_pvv[g]),
                .input_en_override_en(1'b0),
                .input_en_override_val(1'b0),
                .sleep_input_off(sleep_input_off),
                .pin_pullup(portb_pullup[g]),
                .pin_oe(portb_oe[g]),
                .pin_out(portb_out[g]),
                .pin_input_en(portb_input_en[g])
            );
            paof_pin u_c (
                .reg_pullup(c_reg_pull[g]),
                .reg_dir(portc_dir[g]),
                .reg_outval(portc_latch[g]),
                .pullup_override_en(c_pue[g] | legacy_mode),
                .pullup_override_val(1'b0),
                .dir_override_en(c_dde[g]),
                .dir_override_val(1'b1),
                .outval_override_en(c_pve[g]),
                .outval_override_val(c_pvv[g]),
                .input_en_override_en(1'b0),
                .input_en_override_val(1'b0),
                .sleep_input_off(sleep_input_off),
                .pin_pullup(portc_pullup[g]),
                .pin_oe(portc_oe[g]),
                .pin_out(portc_out[g]),
                .pin_input_en(portc_input_en[g])
            );
            paof_pin u_d (
                .reg_pullup(d_reg_pull[g]),
                .reg_dir(portd_dir[g]),
                .reg_outval(portd_latch[g]),
                .pullup_override_en(d_pue[g]),
                .pullup_override_val(d_puv[g]),
                .dir_override_en(d_dde[g]),
                .dir_override_val(d_ddv[g]),
                .outval_override_en(d_pve[g]),
                .outval_override_val(d_pvv[g]),
                .input_en_override_en(d_die[g]),
                .input_en_override_val(1'b1),
                .sleep_input_off(sleep_input_off),
                .pin_pullup(portd_pullup[g]),
                .pin_oe(portd_oe[g]),
                .pin_out(portd_out[g]),
                .pin_input_en(portd_input_en[g])
            );
        end
    endgenerate

    // Peripheral-facing inputs are registered so that every output to a peripheral comes from a flop.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spi_master_input <= 1'b0;
            spi_slave_input <= 1'b0;
            spi_clock_input <= 1'b0;
            spi_select_active <= 1'b0;
            timer_b_ext_clock <= 1'b0;
            wide_timer_ext_clock <= 1'b0;
            wide_timer_capture_in <= 1'b0;
            ext_irq_two <= 1'b0;
            ext_irq_three <= 1'b0;
            usart_b_sync_clock_in <= 1'b0;
            // The receive line rests high, so leaving reset shows no start bit.
            usart_b_receive <= 1'b1;
        end else begin
            // Pins other than select, sync clock and receive are copied whatever the role; each consumer gates on its own enable.
            spi_master_input <= portb_pin_in[`PAOF_PB_MISO];
            spi_slave_input <= portb_pin_in[`PAOF_PB_MOSI];
            spi_clock_input <= portb_pin_in[`PAOF_PB_SCK];
            spi_select_active <= spi_slave & ~portb_pin_in[`PAOF_PB_SS];

            timer_b_ext_clock <= portd_pin_in[7];
            wide_timer_ext_clock <= portd_pin_in[6];
            wide_timer_capture_in <= portd_pin_in[4];

            ext_irq_two <= portd_pin_in[`PAOF_PD_RX];
            ext_irq_three <= portd_pin_in[`PAOF_PD_TX];
            // The clock input reads zero whenever the pin is not a clock input.
            usart_b_sync_clock_in <= xck_on & ~portd_dir[`PAOF_PD_XCK] &
                                     portd_pin_in[`PAOF_PD_XCK];
            usart_b_receive <= rx_on ? portd_pin_in[`PAOF_PD_RX] : 1'b1;
        end
    end
endmodule

// ---- verification/paof_far.sv ----
// Far-side pin model: resolves pad levels from device drive, pull-ups and outside drivers.
`timescale 1ns/100ps
module paof_far (
    // Device pin controls
    input wire [7:0] oe_b, out_b, pull_b, oe_d, out_d, pull_d,
    // Outside drivers, a fresh random value each cycle, so an undriven pad can change level
    input wire [7:0] drive_b, drive_d,
    // Resolved pad levels
    output wire [7:0] level_b, level_d
);
    // While the device does not drive it, the select pad reads low only while drive_b bit 0 and its pull-up are both low.
    assign level_b = (oe_b & out_b) | (~oe_b & (pull_b | drive_b));
    assign level_d = (oe_d & out_d) | (~oe_d & (pull_d | drive_d));
endmodule

// ---- verification/paof_chk.sv ----
// Concurrent checks on the port override block's outputs.
`timescale 1ns/100ps
module paof_chk (
    // Clock, reset and controls
    input wire clk, resetn, legacy_mode, global_pullup_disable, serial_periph_enable,
    input wire serial_master_select, timer_a_compare_en, timer_a_compare_out, ext_mem_enable,
    input wire ext_irq_two_enable, usart_b_tx_enable, usart_b_transmit, usart_b_rx_enable,
    input wire [2:0] ext_addr_mask,
    // Port views
    input wire [7:0] portb_dir, portb_latch, portd_latch, portb_pin_in, portd_pin_in,
    input wire [7:0] ext_addr_high, portb_pullup, portb_oe, portb_out, portc_oe, portc_out,
    input wire [7:0] portc_pullup, portd_oe, portd_out, portd_pullup, portd_input_en,
    // Registered results
    input wire spi_select_active, usart_b_receive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire slave = serial_periph_enable & ~serial_master_select;
    wire rx_on = usart_b_rx_enable & ~legacy_mode;
    property p_slave_in;
        slave |-> portb_oe[1:0] == 2'b00;
    endproperty
    a_slave_in: assert property (p_slave_in) else $error("slave pins not input");
    property p_mst_dir;
        serial_periph_enable && serial_master_select |-> portb_oe[1:0] == portb_dir[1:0];
    endproperty
    a_mst_dir: assert property (p_mst_dir) else $error("master pin direction");
    property p_pull_b;
        portb_pullup == (portb_latch & ~portb_oe & ~{8{global_pullup_disable}});
    endproperty
    a_pull_b: assert property (p_pull_b) else $error("port B pull-up");
    property p_sel;
        $past(resetn) |-> spi_select_active == $past(slave & ~portb_pin_in[0]);
    endproperty
    a_sel: assert property (p_sel) else $error("select activity");
    property p_cmp;
        timer_a_compare_en |-> portb_out[4] == timer_a_compare_out;
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare value");
    property p_legc;
        legacy_mode |-> portc_oe == 8'hff && portc_pullup == 8'h00;
    endproperty
    a_legc: assert property (p_legc) else $error("legacy port C");
    property p_a8;
        ext_mem_enable && ext_addr_mask != 3'h7 |->
            portc_oe[1:0] == 2'b11 && portc_out[1:0] == ext_addr_high[1:0];
    endproperty
    a_a8: assert property (p_a8) else $error("low address pins");
    property p_tx;
        usart_b_tx_enable && !legacy_mode |->
            portd_oe[3] && portd_out[3] == usart_b_transmit && !portd_pullup[3];
    endproperty
    a_tx: assert property (p_tx) else $error("transmit pin");
    property p_rx;
        rx_on |-> !portd_oe[2] && portd_pullup[2] == (portd_latch[2] & ~global_pullup_disable);
    endproperty
    a_rx: assert property (p_rx) else $error("receive pin");
    property p_rcv;
        $past(resetn) |-> usart_b_receive == ($past(rx_on) ? $past(portd_pin_in[2]) : 1'b1);
    endproperty
    a_rcv: assert property (p_rcv) else $error("receive data");
    property p_irq;
        ext_irq_two_enable |-> portd_input_en[2];
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt input off");
    c_slave: cover property (slave && !portb_pin_in[0]);
    c_tx: cover property (usart_b_tx_enable && !legacy_mode);
    c_claim: cover property (ext_mem_enable && ext_addr_mask == 3'h0);
endmodule
bind paof_top paof_chk u_paof_chk (.*);

// ---- verification/port_alt_function_override_tb.sv ----
// Random self-checking bench for the port override block.
`timescale 1ns/100ps
module port_alt_function_override_tb;
    logic clk = 1'b0, resetn, legacy_mode, global_pullup_disable, sleep_input_off;
    logic [7:0] portb_dir, portb_latch, portc_dir, portc_latch, portd_dir, portd_latch;
    logic [7:0] drive_b, drive_d, ext_addr_high;
    wire [7:0] portb_pin_in, portd_pin_in;
    logic serial_periph_enable, serial_master_select, spi_master_output, spi_slave_output;
    logic spi_clock_output, spi_master_input, spi_slave_input, spi_clock_input;
    logic spi_select_active, timer_a_compare_en, timer_a_compare_out, wide_timer_compare_a_en;
    logic wide_timer_compare_a, wide_timer_compare_b_en, wide_timer_compare_b;
    logic wide_timer_compare_c_en, wide_timer_compare_c, timer_b_compare_en;
    logic timer_b_compare_out, ext_mem_enable, timer_b_ext_clock, wide_timer_ext_clock;
    logic [2:0] ext_addr_mask;
    logic wide_timer_capture_in, ext_irq_two_enable, ext_irq_three_enable, ext_irq_two;
    logic ext_irq_three, usart_b_sync_mode, usart_b_sync_clock_out, usart_b_tx_enable;
    logic usart_b_transmit, usart_b_rx_enable, usart_b_sync_clock_in, usart_b_receive;
    wire [7:0] portb_pullup, portb_oe, portb_out, portb_input_en, portc_pullup, portc_oe;
    wire [7:0] portc_out, portc_input_en, portd_pullup, portd_oe, portd_out, portd_input_en;
    wire slave = serial_periph_enable & ~serial_master_select;
    wire ul = ~legacy_mode;
    wire [7:0] nopud = {8{~global_pullup_disable}};
    int failures = 0, comparisons = 0, seed = 92, n;
    logic [7:0] want;
    always #2 clk = ~clk;
    paof_top u_paof_top (.*);
    paof_far u_paof_far (.oe_b(portb_oe), .out_b(portb_out), .pull_b(portb_pullup),
        .oe_d(portd_oe), .out_d(portd_out), .pull_d(portd_pullup), .drive_b(drive_b),
        .drive_d(drive_d), .level_b(portb_pin_in), .level_d(portd_pin_in));
    task check(input [7:0] seen, input [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, exp);
        end
    endtask
    task drive(input [127:0] r);
        {legacy_mode, global_pullup_disable, sleep_input_off, portb_dir, portb_latch, portc_dir,
            portc_latch, portd_dir, portd_latch, drive_b, drive_d, ext_addr_high, ext_addr_mask,
            serial_periph_enable, serial_master_select, spi_master_output, spi_slave_output,
            spi_clock_output, timer_a_compare_en, timer_a_compare_out, wide_timer_compare_a_en,
            wide_timer_compare_a, wide_timer_compare_b_en, wide_timer_compare_b,
            wide_timer_compare_c_en, wide_timer_compare_c, timer_b_compare_en,
            timer_b_compare_out, ext_mem_enable, ext_irq_two_enable, ext_irq_three_enable,
            usart_b_sync_mode, usart_b_sync_clock_out, usart_b_tx_enable, usart_b_transmit,
            usart_b_rx_enable} = r[100:0];
    endtask
    task check_regs;
        logic [7:0] regs;
        regs = {spi_select_active, spi_clock_input, spi_slave_input, spi_master_input,
            timer_b_ext_clock, wide_timer_ext_clock, wide_timer_capture_in, ext_irq_two};
        if (!resetn) begin
            check({regs[7:1], ext_irq_two | ext_irq_three | usart_b_sync_clock_in}, 8'h00);
            check({7'h00, usart_b_receive}, 8'h01);
        end else begin
            want = {slave & ~portb_pin_in[0], portb_pin_in[1], portb_pin_in[2], portb_pin_in[3],
                portd_pin_in[7], portd_pin_in[6], portd_pin_in[4], portd_pin_in[2]};
            check(regs, want);
            want = {5'h00, portd_pin_in[3], usart_b_sync_mode & ul & ~portd_dir[5] & portd_pin_in[5],
                (usart_b_rx_enable & ul) ? portd_pin_in[2] : 1'b1};
            check({5'h00, ext_irq_three, usart_b_sync_clock_in, usart_b_receive}, want);
        end
    endtask
    task check_comb;
        logic [7:0] b_oe, c_oe, c_out, d_oe, d_out;
        logic en7, claim;
        int i;
        b_oe = portb_dir;
        if (slave) b_oe[2:0] = 3'h0;
        if (serial_periph_enable & serial_master_select) b_oe[3] = 1'b0;
        check(portb_oe, b_oe);
        check(portb_pullup, portb_latch & ~b_oe & nopud);
        want = {4'h0, slave ? spi_slave_output : portb_latch[3],
            (serial_periph_enable & serial_master_select) ? spi_master_output : portb_latch[2],
            (serial_periph_enable & serial_master_select) ? spi_clock_output : portb_latch[1],
            portb_latch[0]};
        check({4'h0, portb_out[3:0]}, want);
        en7 = timer_b_compare_en | (wide_timer_compare_c_en & ul);
        want = {en7 ? (timer_b_compare_en & timer_b_compare_out) |
            (wide_timer_compare_c_en & ul & wide_timer_compare_c) : portb_latch[7],
            wide_timer_compare_b_en ? wide_timer_compare_b : portb_latch[6],
            wide_timer_compare_a_en ? wide_timer_compare_a : portb_latch[5],
            timer_a_compare_en ? timer_a_compare_out : portb_latch[4], 4'h0};
        check({portb_out[7:4], 4'h0}, want);
        for (i = 0; i < 8; i++) begin
            claim = ext_mem_enable && ((legacy_mode ? 0 : int'(ext_addr_mask)) < ((i >= 2) ? 8 - i : 7));
            c_oe[i] = claim | legacy_mode | portc_dir[i];
            c_out[i] = claim ? ext_addr_high[i] : portc_latch[i];
        end
        check(portc_oe, c_oe);
        check(portc_out, c_out);
        check(portc_pullup, portc_latch & ~c_oe & nopud);
        d_oe = portd_dir;
        d_out = portd_latch;
        if (usart_b_tx_enable & ul) {d_oe[3], d_out[3]} = {1'b1, usart_b_transmit};
        if (usart_b_rx_enable & ul) d_oe[2] = 1'b0;
        if (usart_b_sync_mode & portd_dir[5] & ul) d_out[5] = usart_b_sync_clock_out;
        check(portd_oe, d_oe);
        check(portd_out, d_out);
        check(portd_pullup, portd_latch & ~d_oe & nopud);
        want = {4'h0, ext_irq_three_enable, ext_irq_two_enable, 2'h0} | {8{~sleep_input_off}};
        check(portd_input_en, want);
        check(portb_input_en, {8{~sleep_input_off}});
        check(portc_input_en, {8{~sleep_input_off}});
    endtask
    task end_of_test;
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #40000;
        failures = failures + 1;
        end_of_test;
    end
    initial begin
        resetn = 1'b0;
        drive(128'h0);
        repeat (20) @(negedge clk);
        check_regs;
        resetn = 1'b1;
        for (n = 0; n < 2000; n++) begin
            @(negedge clk);
            check_regs;
            resetn = !(n >= 1000 && n < 1003);
            drive({$random(seed), $random(seed), $random(seed), $random(seed)});
            #1;
            check_comb;
        end
        end_of_test;
    end
endmodule
